// file: design/dpr_core.sv
// Dual-port block memory with split mode, FIFO controller, ECC and cascade path.
//
// What this block does
// - Two independent ports share the 36Kb stored array and the one clock, ref_clk.
// - Array works as one 36Kb or two independent 18Kb halves.
// - Reads and writes happen on the port clock edge.
// - Data, address, enable and write enable are registered before use.
// - Registered address holds until next access unless latching is off.
// - Optional output register adds one cycle of read latency.
// - Output during write shows old word, new word, or stays unchanged.
// - 36Kb shapes from 32K by 1 up to 512 by 72, parity optional.
// - The two ports may use different shapes, in memory and FIFO mode.
// - 18Kb shapes from 16K by 1 up to 512 by 36.
// - Widest shapes only in split and FIFO modes: one port writes, one reads.
// - In split mode one side is fixed at 36 or 72 bits.
// - 64-bit words get eight check bits; single fixed, double flagged.
// - Encoder and corrector also serve an external 72-bit memory.
// - Array can be a 36Kb or 18Kb FIFO.
// - FIFO advances its own pointers and gives four flags.
// - User sets programmable full and empty thresholds.
// - FIFO width and depth programmable, write and read widths may differ.
// - Cascade path joins adjacent instances into deeper FIFOs.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "dpr_consts.svh"

module dpr_core #(
    parameter int BUS_AW = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [BUS_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire dpr_pkg::dpr_port_in_type port_a,
    input wire dpr_pkg::dpr_port_in_type port_b,
    output dpr_pkg::dpr_port_out_type dout_a,
    output dpr_pkg::dpr_port_out_type dout_b,
    output dpr_pkg::dpr_flags_type fifo_flags,
    input wire dpr_pkg::dpr_cas_type cas_in,
    input wire logic cas_stall,
    input wire logic [`DPR_CORE_W-1:0] ext_enc_data,
    output logic [`DPR_CHK_W-1:0] ext_enc_check,
    input wire logic [`DPR_DATA_W-1:0] ext_dec_word,
    output dpr_pkg::dpr_ecc_type ext_dec
);

    if (BUS_AW < 4) begin : g_bad_aw
        $error("dpr_core: BUS_AW must be at least 4");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Check bits: data sits at non power-of-two positions 3..71
    function automatic logic [7:0] dpr_ecc_enc(input logic [63:0] d);
        logic [7:0] c;
        int j;
        c = '0;
        j = 0;
        for (int pos = 3; pos < 72; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                if (d[j]) begin
                    c[6:0] = c[6:0] ^ 7'(pos);
                end
                j++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : dpr_ecc_enc

    // Syndrome decode; overall parity splits single from double errors
    function automatic dpr_pkg::dpr_ecc_type dpr_ecc_dec(input logic [71:0] w);
        dpr_pkg::dpr_ecc_type r;
        logic [7:0] c;
        logic [6:0] s;
        logic p;
        int j;
        c = dpr_ecc_enc(w[63:0]);
        s = c[6:0] ^ w[70:64];
        p = ^w;
        r.data = w[63:0];
        j = 0;
        for (int pos = 3; pos < 72; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                if (p && (7'(pos) == s)) begin
                    r.data[j] = ~r.data[j];
                end
                j++;
            end
        end
        r.sbit = p;
        r.dbit = !p && (s != 7'h00);
        return r;
    endfunction : dpr_ecc_dec

    // Mask for the data bits of one word of a width code
    function automatic logic [63:0] dpr_dmask(input logic [2:0] code);
        logic [6:0] n;
        n = 7'h01 << code;
        return ~({64{1'b1}} << n);
    endfunction : dpr_dmask

    // Mask for the parity bits; narrow words carry none
    function automatic logic [7:0] dpr_pmask(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h1 << (code - `DPR_CODE_PAR);
        return (code < `DPR_CODE_PAR) ? 8'h00 : ~(8'hFF << n);
    endfunction : dpr_pmask

    // One word out of a row; lane is the bit offset inside the row
    function automatic logic [71:0] dpr_extract(input logic [71:0] row, input logic [2:0] code,
                                                input logic [5:0] lane);
        logic [71:0] w;
        w = '0;
        w[63:0] = (row[63:0] >> lane) & dpr_dmask(code);
        w[71:64] = (row[71:64] >> lane[5:3]) & dpr_pmask(code);
        return w;
    endfunction : dpr_extract

    // Merge one word into a row, untouched lanes keep their bits
    function automatic logic [71:0] dpr_merge(input logic [71:0] row, input logic [71:0] din,
                                              input logic [2:0] code, input logic [5:0] lane);
        logic [71:0] r;
        r[63:0] = (row[63:0] & ~(dpr_dmask(code) << lane))
            | ((din[63:0] & dpr_dmask(code)) << lane);
        r[71:64] = (row[71:64] & ~(dpr_pmask(code) << lane[5:3]))
            | ((din[71:64] & dpr_pmask(code)) << lane[5:3]);
        return r;
    endfunction : dpr_merge

    // Width code allowed by mode and array size
    function automatic logic [2:0] dpr_eff_code(input logic [2:0] code,
                                                input dpr_pkg::dpr_ctrl_type c);
        logic [2:0] lim;
        if (c.mode == dpr_pkg::DPR_TRUE_DUAL) begin
            lim = c.half ? `DPR_CODE_18 : `DPR_CODE_36;
        end else begin
            lim = c.half ? `DPR_CODE_36 : `DPR_CODE_72;
        end
        return (code > lim) ? lim : code;
    endfunction : dpr_eff_code

    // Lane address to bit offset in the array; 18Kb keeps the half select
    function automatic logic [14:0] dpr_offset(input logic [14:0] addr, input logic [2:0] code,
                                               input logic half, input logic hsel);
        logic [14:0] t;
        t = 15'(addr << code);
        if (half) begin
            t[14] = hsel;
        end
        return t;
    endfunction : dpr_offset

    ////////////////////////////////////////////////////////////////////////////
    // State, array and combinational helpers

    dpr_pkg::dpr_state_type st;
    dpr_pkg::dpr_state_type next_st;
    logic [`DPR_DATA_W-1:0] mem [0:`DPR_ROWS-1];
    logic [2:0] code_a;
    logic [2:0] code_b;
    logic [71:0] row_a;
    logic [71:0] row_b;
    logic [71:0] wdin_a;
    logic [71:0] wdin_b;
    logic [71:0] nrow_a;
    logic [71:0] nrow_b;
    logic same_row;
    logic [15:0] cap;
    logic [15:0] step_a;
    logic [15:0] step_b;
    logic split;
    logic fifo;

    assign split = (st.ctrl.mode == dpr_pkg::DPR_SPLIT_RW);
    assign fifo = (st.ctrl.mode == dpr_pkg::DPR_FIFO);
    assign code_a = dpr_eff_code(st.width_a, st.ctrl);
    // One side of split mode must be 36 or 72 wide
    assign code_b = (split && code_a < `DPR_CODE_36 && dpr_eff_code(st.width_b, st.ctrl)
        < `DPR_CODE_36) ? `DPR_CODE_36 : dpr_eff_code(st.width_b, st.ctrl);
    assign cap = st.ctrl.half ? `DPR_CAP_HALF : `DPR_CAP_FULL;
    assign step_a = 16'h0001 << code_a;
    assign step_b = 16'h0001 << code_b;

    // Array rows seen by the registered stage; reads are read-before-write
    assign row_a = mem[st.sa.off[14:6]];
    assign row_b = mem[st.sb.off[14:6]];
    assign same_row = (st.sa.off[14:6] == st.sb.off[14:6]) && st.sa.we;

    // Check bits replace parity on 64-bit words when ECC is on
    always_comb begin
        wdin_a = st.sa.din;
        wdin_b = st.sb.din;
        if (st.ctrl.ecc_en && code_a == `DPR_CODE_72) begin
            wdin_a[71:64] = dpr_ecc_enc(st.sa.din[63:0]);
        end
        if (st.ctrl.ecc_en && code_b == `DPR_CODE_72) begin
            wdin_b[71:64] = dpr_ecc_enc(st.sb.din[63:0]);
        end
        nrow_a = dpr_merge(row_a, wdin_a, code_a, st.sa.off[5:0]);
        // Same-row collision: B lands on top of A so both lanes survive
        nrow_b = dpr_merge(same_row ? nrow_a : row_b, wdin_b, code_b, st.sb.off[5:0]);
    end

    // Array write on the clock edge after the inputs were registered
    always_ff @(posedge ref_clk) begin
        if (st.sa.we) begin
            mem[st.sa.off[14:6]] <= nrow_a;
        end
        if (st.sb.we) begin
            mem[st.sb.off[14:6]] <= nrow_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Read result of one port, honouring write mode and ECC
    function automatic dpr_pkg::dpr_port_out_type dpr_result(input logic [71:0] row,
            input logic [71:0] wdin, input logic [2:0] code, input logic [5:0] lane,
            input logic we, input dpr_pkg::dpr_wmode_type wm, input logic ecc);
        dpr_pkg::dpr_port_out_type r;
        dpr_pkg::dpr_ecc_type e;
        r.valid = 1'b1;
        r.sbit = 1'b0;
        r.dbit = 1'b0;
        r.data = dpr_extract(row, code, lane);
        if (we && wm == dpr_pkg::DPR_WRITE_FIRST) begin
            r.data = dpr_extract(wdin, code, 6'h00);
        end else if (ecc && code == `DPR_CODE_72) begin
            e = dpr_ecc_dec(r.data);
            r.data[63:0] = e.data;
            r.sbit = e.sbit;
            r.dbit = e.dbit;
        end
        return r;
    endfunction : dpr_result

    always_comb begin
        logic push;
        logic pop;
        logic [15:0] used;
        logic [15:0] pf_words;
        logic [15:0] pe_words;
        next_st = st;
        push = 1'b0;
        pop = 1'b0;

        // Register bus: writes steer the block, reads answer a cycle later
        next_st.rdata = 32'h0000_0000;
        if (reg_wr) begin
            if (reg_addr == BUS_AW'(`DPR_REG_CTRL)) begin
                next_st.ctrl = dpr_pkg::dpr_ctrl_type'(reg_wdata[`DPR_CTRL_W-1:0]);
            end
            if (reg_addr == BUS_AW'(`DPR_REG_WIDTH)) begin
                next_st.width_a = reg_wdata[`DPR_WID_A_LSB +: 3];
                next_st.width_b = reg_wdata[`DPR_WID_B_LSB +: 3];
            end
            if (reg_addr == BUS_AW'(`DPR_REG_THRESH)) begin
                next_st.pf_thr = reg_wdata[15:0];
                next_st.pe_thr = reg_wdata[`DPR_THR_PE_LSB +: 16];
            end
        end
        if (reg_rd) begin
            if (reg_addr == BUS_AW'(`DPR_REG_CTRL)) begin
                next_st.rdata[`DPR_CTRL_W-1:0] = st.ctrl;
            end
            if (reg_addr == BUS_AW'(`DPR_REG_WIDTH)) begin
                next_st.rdata[`DPR_WID_A_LSB +: 3] = st.width_a;
                next_st.rdata[`DPR_WID_B_LSB +: 3] = st.width_b;
            end
            if (reg_addr == BUS_AW'(`DPR_REG_THRESH)) begin
                next_st.rdata = {st.pe_thr, st.pf_thr};
            end
            if (reg_addr == BUS_AW'(`DPR_REG_STATUS)) begin
                next_st.rdata[3:0] = {st.flags.pempty, st.flags.pfull, st.flags.empty,
                    st.flags.full};
                next_st.rdata[`DPR_ST_SERR] = st.err_s;
                next_st.rdata[`DPR_ST_DERR] = st.err_d;
                next_st.rdata[`DPR_ST_CNT_LSB +: 16] = st.cnt;
            end
        end

        // Stage two: array access from the registered inputs
        next_st.rd_a.valid = 1'b0;
        next_st.rd_b.valid = 1'b0;
        if (st.sa.en && !(st.sa.we && st.ctrl.wm_a == dpr_pkg::DPR_NO_CHANGE)) begin
            next_st.rd_a = dpr_result(row_a, wdin_a, code_a, st.sa.off[5:0], st.sa.we,
                st.ctrl.wm_a, st.ctrl.ecc_en);
        end
        if (st.sb.en && !(st.sb.we && st.ctrl.wm_b == dpr_pkg::DPR_NO_CHANGE)) begin
            next_st.rd_b = dpr_result(row_b, wdin_b, code_b, st.sb.off[5:0], st.sb.we,
                st.ctrl.wm_b, st.ctrl.ecc_en);
        end
        // Output register trades a cycle of latency for timing margin
        next_st.q_a = st.ctrl.out_reg ? st.rd_a : next_st.rd_a;
        next_st.q_b = st.ctrl.out_reg ? st.rd_b : next_st.rd_b;
        next_st.q_a.valid = st.ctrl.out_reg ? st.rd_a.valid : next_st.rd_a.valid;
        next_st.q_b.valid = st.ctrl.out_reg ? st.rd_b.valid : next_st.rd_b.valid;

        // Sticky error status; a new error wins over a clear
        if (reg_wr && reg_addr == BUS_AW'(`DPR_REG_STATUS)) begin
            next_st.err_s = st.err_s & ~reg_wdata[`DPR_ST_SERR];
            next_st.err_d = st.err_d & ~reg_wdata[`DPR_ST_DERR];
        end
        next_st.err_s = next_st.err_s | next_st.rd_a.sbit & next_st.rd_a.valid
            | next_st.rd_b.sbit & next_st.rd_b.valid;
        next_st.err_d = next_st.err_d | next_st.rd_a.dbit & next_st.rd_a.valid
            | next_st.rd_b.dbit & next_st.rd_b.valid;

        // Stage one: capture port inputs before they touch the array
        if (!fifo) begin
            next_st.sa.en = port_a.en && !split;
            next_st.sa.we = port_a.en && port_a.we;
            next_st.sb.en = port_b.en;
            next_st.sb.we = port_b.en && port_b.we && !split;
            next_st.sa.we = next_st.sa.we | (split && port_a.en && port_a.we);
            if (port_a.en || st.ctrl.alatch_off) begin
                next_st.sa.off = dpr_offset(port_a.addr, code_a, st.ctrl.half,
                    st.ctrl.hsel_a);
            end
            if (port_b.en || st.ctrl.alatch_off) begin
                next_st.sb.off = dpr_offset(port_b.addr, code_b, st.ctrl.half,
                    st.ctrl.hsel_b);
            end
            if (port_a.en) begin
                next_st.sa.din = port_a.din;
            end
            if (port_b.en) begin
                next_st.sb.din = port_b.din;
            end
        end else begin
            // FIFO: A writes (or the cascade input), B reads, pointers run themselves
            push = (st.ctrl.casc_en ? cas_in.valid : (port_a.en && port_a.we))
                && !st.flags.full;
            pop = (st.ctrl.casc_en ? !cas_stall : port_b.en) && !st.flags.empty;
            next_st.sa.en = 1'b0;
            next_st.sa.we = push;
            next_st.sb.en = pop;
            next_st.sb.we = 1'b0;
            if (push) begin
                next_st.sa.off = dpr_offset(st.wptr[14:0], 3'h0, st.ctrl.half,
                    st.ctrl.hsel_a);
                next_st.sa.din = st.ctrl.casc_en ? cas_in.data : port_a.din;
                next_st.wptr = (st.wptr + step_a) & (cap - 16'h0001);
            end
            if (pop) begin
                next_st.sb.off = dpr_offset(st.rptr[14:0], 3'h0, st.ctrl.half,
                    st.ctrl.hsel_a);
                next_st.rptr = (st.rptr + step_b) & (cap - 16'h0001);
            end
        end

        // Occupancy counted in bits so mixed widths stay consistent
        used = st.cnt + (push ? step_a : 16'h0000) - (pop ? step_b : 16'h0000);
        if (reg_wr && reg_addr == BUS_AW'(`DPR_REG_CTRL)) begin
            // Reconfiguring restarts the FIFO empty
            used = 16'h0000;
            next_st.wptr = 16'h0000;
            next_st.rptr = 16'h0000;
        end
        next_st.cnt = used;
        pf_words = used >> code_a;
        pe_words = used >> code_b;
        next_st.flags.full = fifo && (cap - used < step_a);
        next_st.flags.empty = !fifo || (used < step_b);
        next_st.flags.pfull = fifo && (pf_words >= st.pf_thr);
        next_st.flags.pempty = !fifo || (pe_words <= st.pe_thr);

        // External memory check-bit generator and corrector
        next_st.ext_chk = dpr_ecc_enc(ext_enc_data);
        next_st.ext_dec = dpr_ecc_dec(ext_dec_word);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.ctrl <= dpr_pkg::dpr_ctrl_type'(`DPR_CTRL_RST);
            st.width_a <= `DPR_WIDTH_RST;
            st.width_b <= `DPR_WIDTH_RST;
            st.pf_thr <= `DPR_THR_RST;
            st.pe_thr <= `DPR_THR_RST;
            st.flags.empty <= 1'b1;
            st.flags.pempty <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = st.rdata;
    assign dout_a = st.q_a;
    assign dout_b = st.q_b;
    assign fifo_flags = st.flags;
    assign ext_enc_check = st.ext_chk;
    assign ext_dec = st.ext_dec;

endmodule : dpr_core

// file: include/dpr_consts.svh
// Constants for the dual-port memory and FIFO block: offsets, fields, resets, sizes.
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// Array geometry
`define DPR_DATA_W 72
`define DPR_CORE_W 64
`define DPR_CHK_W 8
`define DPR_ROWS 512
`define DPR_OFF_W 15
`define DPR_PTR_W 16
`define DPR_CAP_FULL 16'h8000
`define DPR_CAP_HALF 16'h4000

// Width codes: data bits per word are 1 << code
`define DPR_CODE_PAR 3'h3
`define DPR_CODE_18 3'h4
`define DPR_CODE_36 3'h5
`define DPR_CODE_72 3'h6

// Register offsets, byte addresses
`define DPR_REG_CTRL 4'h0
`define DPR_REG_WIDTH 4'h4
`define DPR_REG_THRESH 4'h8
`define DPR_REG_STATUS 4'hC

// Field positions
`define DPR_CTRL_W 13
`define DPR_WID_A_LSB 0
`define DPR_WID_B_LSB 4
`define DPR_THR_PE_LSB 16
`define DPR_ST_SERR 4
`define DPR_ST_DERR 5
`define DPR_ST_CNT_LSB 16

// Reset values
`define DPR_CTRL_RST 13'h0000
`define DPR_WIDTH_RST 3'h5
`define DPR_THR_RST 16'h0000

`endif

// file: include/dpr_pkg.sv
// Types shared by the dual-port memory and FIFO block and its users.
`include "dpr_consts.svh"

package dpr_pkg;

    typedef enum logic [1:0] {
        DPR_TRUE_DUAL = 2'h0,
        DPR_SPLIT_RW = 2'h1,
        DPR_FIFO = 2'h3
    } dpr_mode_type;

    typedef enum logic [1:0] {
        DPR_READ_FIRST = 2'h0,
        DPR_WRITE_FIRST = 2'h1,
        DPR_NO_CHANGE = 2'h3
    } dpr_wmode_type;

    typedef struct packed {
        logic casc_en;
        logic hsel_b;
        logic hsel_a;
        logic ecc_en;
        logic alatch_off;
        dpr_wmode_type wm_b;
        dpr_wmode_type wm_a;
        logic out_reg;
        logic half;
        dpr_mode_type mode;
    } dpr_ctrl_type;

    typedef struct packed {
        logic en;
        logic we;
        logic [`DPR_OFF_W-1:0] addr;
        logic [`DPR_DATA_W-1:0] din;
    } dpr_port_in_type;

    typedef struct packed {
        logic en;
        logic we;
        logic [`DPR_OFF_W-1:0] off;
        logic [`DPR_DATA_W-1:0] din;
    } dpr_stage_type;

    typedef struct packed {
        logic valid;
        logic [`DPR_DATA_W-1:0] data;
        logic sbit;
        logic dbit;
    } dpr_port_out_type;

    typedef struct packed {
        logic valid;
        logic [`DPR_DATA_W-1:0] data;
    } dpr_cas_type;

    typedef struct packed {
        logic full;
        logic empty;
        logic pfull;
        logic pempty;
    } dpr_flags_type;

    typedef struct packed {
        logic [`DPR_CORE_W-1:0] data;
        logic sbit;
        logic dbit;
    } dpr_ecc_type;

    typedef struct packed {
        dpr_ctrl_type ctrl;
        logic [2:0] width_a;
        logic [2:0] width_b;
        logic [15:0] pf_thr;
        logic [15:0] pe_thr;
        dpr_stage_type sa;
        dpr_stage_type sb;
        dpr_port_out_type rd_a;
        dpr_port_out_type rd_b;
        dpr_port_out_type q_a;
        dpr_port_out_type q_b;
        logic [`DPR_PTR_W-1:0] wptr;
        logic [`DPR_PTR_W-1:0] rptr;
        logic [`DPR_PTR_W-1:0] cnt;
        dpr_flags_type flags;
        logic err_s;
        logic err_d;
        logic [31:0] rdata;
        logic [`DPR_CHK_W-1:0] ext_chk;
        dpr_ecc_type ext_dec;
    } dpr_state_type;

endpackage : dpr_pkg

// file: sim/dpr_core_properties.sv
// Port checks for the dual-port memory and FIFO block.
`timescale 1ns/10ps
`include "dpr_consts.svh"
module dpr_core_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire dpr_pkg::dpr_port_in_type port_a,
    input wire dpr_pkg::dpr_port_in_type port_b,
    input wire dpr_pkg::dpr_port_out_type dout_a,
    input wire dpr_pkg::dpr_port_out_type dout_b,
    input wire dpr_pkg::dpr_flags_type fifo_flags,
    input wire logic cas_stall,
    input wire logic [`DPR_CORE_W-1:0] ext_enc_data,
    input wire logic [`DPR_CHK_W-1:0] ext_enc_check
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    // Bus, flags and latency relations
    property p_rdata_slot; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside slot");
    property p_fe_excl; !(fifo_flags.full && fifo_flags.empty); endproperty
    a_fe_excl: assert property (p_fe_excl) else $error("full and empty together");
    property p_pe_empty; fifo_flags.empty |-> fifo_flags.pempty; endproperty
    a_pe_empty: assert property (p_pe_empty) else $error("empty without prog empty");
    // Skip the edge after reset release
    property p_enc; $past(rst_b) && $stable(ext_enc_data) |=> $stable(ext_enc_check); endproperty
    a_enc: assert property (p_enc) else $error("check bits not a function of data");
    property p_va; dout_a.valid |-> $past(port_a.en, 2) || $past(port_a.en, 3); endproperty
    a_va: assert property (p_va) else $error("port A result without request");
    property p_vb;
        dout_b.valid |-> $past(port_b.en, 2) || $past(port_b.en, 3) || $past(!cas_stall, 2)
            || $past(!cas_stall, 3);
    endproperty
    a_vb: assert property (p_vb) else $error("port B result without request");
    property p_ha; !dout_a.valid |-> $stable(dout_a.data); endproperty
    a_ha: assert property (p_ha) else $error("port A data moved");
    property p_hb; !dout_b.valid |-> $stable(dout_b.data); endproperty
    a_hb: assert property (p_hb) else $error("port B data moved");
    c_ra: cover property (dout_a.valid);
    c_full: cover property (fifo_flags.full);
    c_oreg: cover property (dout_b.valid && $past(port_b.en, 3));
endmodule : dpr_core_props
bind dpr_core dpr_core_props u_props (.*);

// file: sim/dpr_user.sv
// Fabric-side model driving both memory ports.
`timescale 1ns/10ps
module dpr_user (
    input wire logic ref_clk,
    output dpr_pkg::dpr_port_in_type port_a,
    output dpr_pkg::dpr_port_in_type port_b
);
    // Both ports idle at time zero
    initial begin
        port_a = '0;
        port_b = '0;
    end
    ////////////////////////////////////////////////////////////////
    // One request cycle; released fields go inverse
    task automatic req(input logic b, input logic we, input logic [14:0] ad, input logic [71:0] d);
        dpr_pkg::dpr_port_in_type p;
        p = '{en: 1'b1, we: we, addr: ad, din: d};
        @(posedge ref_clk);
        if (b) port_b <= p;
        else port_a <= p;
        @(posedge ref_clk);
        p = ~p;
        p.en = 1'b0;
        if (b) port_b <= p;
        else port_a <= p;
    endtask : req
endmodule : dpr_user

// file: sim/tb_dpr_core.sv
// Self-checking bench for the dual-port memory and FIFO block.
`timescale 1ns/10ps
`include "dpr_consts.svh"
module tb_dpr_core;
    localparam logic [71:0] M = 72'h0F_0000_0000_FFFF_FFFF;
    localparam logic [71:0] D1 = 72'h05_0000_0000_1234_5678;
    localparam logic [71:0] D2 = 72'h0A_0000_0000_CAFE_F00D;
    logic ref_clk, rst_b, reg_wr, reg_rd, cas_stall;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [63:0] ext_enc_data;
    logic [7:0] ext_enc_check;
    logic [71:0] ext_dec_word;
    dpr_pkg::dpr_port_in_type port_a, port_b;
    dpr_pkg::dpr_port_out_type dout_a, dout_b;
    dpr_pkg::dpr_flags_type fifo_flags;
    dpr_pkg::dpr_cas_type cas_in;
    dpr_pkg::dpr_ecc_type ext_dec;
    int num_errors = 0;
    int tests_run = 0;
    dpr_core u_dut (.*);
    dpr_user u_user (.*);
    ////////////////////////////////////////////////////////////////
    // Shared compare, register and port helpers
    task automatic chk(input logic [71:0] g, input logic [71:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Valid low one cycle early: latency exact
    task automatic op(input logic b, we, input logic [14:0] ad, input logic [71:0] d, m, e,
            input int n, input logic ev);
        dpr_pkg::dpr_port_out_type o;
        u_user.req(b, we, ad, d);
        repeat (n - 1) @(posedge ref_clk);
        #1 o = b ? dout_b : dout_a;
        chk(o.valid, 1'b0);
        @(posedge ref_clk);
        #1 o = b ? dout_b : dout_a;
        chk(o.valid, ev);
        chk(o.data & m, e);
    endtask : op
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        chk(fifo_flags, 4'h5);
        rd(`DPR_REG_CTRL, 32'h0);
        rd(`DPR_REG_WIDTH, 32'h55);
        rd(`DPR_REG_STATUS, 32'hA);
        rd(4'h2, 32'h0);
    endtask : t_reset
    task automatic t_mem();
        wr(`DPR_REG_CTRL, 32'h10);
        op(1'b0, 1'b1, 15'h3, D1, M, D1, 1, 1'b1);
        wr(`DPR_REG_CTRL, 32'h0);
        op(1'b0, 1'b1, 15'h3, D2, M, D1, 1, 1'b1);
        op(1'b1, 1'b0, 15'h3, 72'h0, M, D2, 1, 1'b1);
        wr(`DPR_REG_CTRL, 32'h30);
        op(1'b0, 1'b1, 15'h3, D1, M, D1, 1, 1'b0);
        wr(`DPR_REG_CTRL, 32'h8);
        op(1'b1, 1'b0, 15'h3, 72'h0, M, D1, 2, 1'b1);
    endtask : t_mem
    task automatic t_width();
        wr(`DPR_REG_CTRL, 32'h10);
        wr(`DPR_REG_WIDTH, 32'h35);
        op(1'b0, 1'b1, 15'h0, 72'h01_0000_0000_0000_C3A5, M, 72'h01_0000_0000_0000_C3A5, 1, 1'b1);
        op(1'b1, 1'b0, 15'h1, 72'h0, 72'h01_0000_0000_0000_00FF, 72'hC3, 1, 1'b1);
        op(1'b1, 1'b0, 15'h0, 72'h0, M, 72'h01_0000_0000_0000_00A5, 1, 1'b1);
    endtask : t_width
    // Fill to full then push once more; the extra word must not count
    task automatic t_fifo();
        wr(`DPR_REG_WIDTH, 32'h55);
        wr(`DPR_REG_THRESH, 32'h2);
        wr(`DPR_REG_CTRL, 32'h3);
        op(1'b1, 1'b0, 15'h0, 72'h0, M, 72'h01_0000_0000_0000_00A5, 1, 1'b0);
        for (int i = 0; i < 1024; i++) begin
            u_user.req(1'b0, 1'b1, 15'h0, 72'(i + 1));
            if (i < 2) #1 chk(fifo_flags, i ? 4'h2 : 4'h0);
        end
        u_user.req(1'b0, 1'b1, 15'h0, 72'hFFFF);
        #1 chk(fifo_flags, 4'hA);
        rd(`DPR_REG_STATUS, 32'h8000_0005);
        op(1'b1, 1'b0, 15'h0, 72'h0, M, 72'h1, 1, 1'b1);
    endtask : t_fifo
    task automatic t_ecc();
        logic [7:0] c;
        logic [63:0] d;
        d = 64'h0123_4567_89AB_CDEF;
        @(posedge ref_clk);
        ext_enc_data <= d;
        @(posedge ref_clk);
        #1 c = ext_enc_check;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            ext_dec_word <= {c, d ^ ((64'h1 << k) - 64'h1)};
            @(posedge ref_clk);
            #1 chk({ext_dec.sbit, ext_dec.dbit}, {k == 1, k == 2});
            if (k < 2) chk(ext_dec.data, d);
        end
    endtask : t_ecc
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #1000000;
        num_errors++;
        stop_test();
    end
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, ext_enc_data, ext_dec_word} = '0;
        cas_in = '0;
        cas_stall = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_mem();
        t_width();
        t_fifo();
        t_ecc();
        stop_test();
    end
endmodule : tb_dpr_core
